/* design/charger_cfg_regs.vh */
/*
 * offsets, field positions, reset values and lookup constants for the
 * charger configuration register bank.
 * assumes: included by bare name from design files; definitions only.
 */
`ifndef CHARGER_CFG_REGS_VH
`define CHARGER_CFG_REGS_VH

// ----------------------------------------------------------------------
// register offsets (8-bit register address space)
// ----------------------------------------------------------------------
`define OFS_CHARGE_VOLTAGE_CONFIG 8'h15
`define OFS_CHARGE_TIMER_CONFIG   8'h16
`define OFS_THERMAL_CONFIG        8'h17

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_CHARGE_VOLTAGE_CONFIG 8'h1E
`define RST_CHARGE_TIMER_CONFIG   8'h95
`define RST_THERMAL_CONFIG        8'h24
// decoded settings while in reset, matching the register defaults
`define RST_VREG_TARGET_MV        13'h1068
`define RST_RECHARGE_MV           13'h0FDC
`define RST_FAST_LIMIT_MIN        11'h12C
`define RST_PRECHARGE_LIMIT_MIN   8'h1E
`define RST_TOPOFF_LIMIT_DMIN     8'h40
`define RST_DIE_TEMP_LIMIT_C      7'h64

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define RECHARGE_SEL_BIT      6
`define VREG_CODE_MSB         5
`define VREG_CODE_LSB         0
`define BIAS_SEL_BIT          7
`define TIMER_DOUBLE_BIT      6
`define FAST_TIMER_MSB        5
`define FAST_TIMER_LSB        4
`define PRECHARGE_TIMER_MSB   3
`define PRECHARGE_TIMER_LSB   2
`define TOPOFF_MSB            1
`define TOPOFF_LSB            0
`define BETA_CODE_MSB         7
`define BETA_CODE_LSB         5
`define TEMP_LIMIT_MSB        2
`define TEMP_LIMIT_LSB        0

// ----------------------------------------------------------------------
// decode constants (millivolts, minutes, tenths of a minute, deg C)
// ----------------------------------------------------------------------
`define VREG_BASE_MV          13'h0E10
`define VREG_STEP_MV          13'h0014
`define VREG_MAX_CODE         6'h32
`define RECHARGE_LOW_MV       9'h08C
`define RECHARGE_HIGH_MV      9'h0F0
`define FAST_BASE_MIN         11'h0B4
`define FAST_STEP_MIN         11'h078
`define PRECHARGE_STEP_MIN    8'h0F
`define TOPOFF_STEP_DMIN      8'h40
`define TEMP_BASE_C           7'h50
`define TEMP_STEP_C           7'h05

`endif

/* design/charger_cfg_store.v */
/*
 * one 8-bit configuration register with write gate and registered output.
 * assumes: single clock, async active-low reset, write strobe synchronous.
 */
`default_nettype none

module charger_cfg_store #(
    parameter [7:0] RESET_VALUE = 8'h00
) (
    // clock and reset
    input  wire       ref_clk,
    input  wire       rst_b,
    // write side
    input  wire       wr_en,
    input  wire [7:0] wr_data,
    // stored value
    output reg  [7:0] value
);

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    // write gate is resolved by the caller so lock policy lives in one place
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            value <= RESET_VALUE;
        end else if (wr_en) begin
            value <= wr_data;
        end
    end

endmodule

`default_nettype wire

/* design/charger_config_registers.v */
/*
 * charger configuration register bank: three read/write registers holding
 * regulation voltage, timers, thermistor and thermal settings, plus decoded
 * settings for the analog charger loops.
 * assumes: the serial bus target decodes transfers into a synchronous
 * register port (address, write strobe, read strobe) on ref_clk; the
 * charger lock comes from elsewhere in the device as a synchronous level.
 */
// Functional notes
// - voltage and timer registers obey the charger lock; the thermal one does not.
// - regulation bit 6 picks a recharge threshold 140 mV (0) or 240 mV (1) below target.
// - regulation bits 5:0 hold the voltage code, reset 011110 for 4.20 V.
// - code 0 is 3.60 V plus 20 mV per step, saturating at 4.60 V from code 32h up.
// - timer bit 7 picks 100 k thermistor at 5 uA (0) or 10 k at 50 uA (1), reset 1.
// - timer bit 6 doubles both precharge and fast-charge safety timers, reset 0.
// - timer bits 5:4 set fast-charge timeout 3/5/7/9 hours, reset 01.
// - timer bits 3:2 set precharge timeout 15/30/45/60 minutes, reset 01.
// - timer bits 1:0 set top-off 0/6.4/12.8/19.2 minutes, reset 01.
// - thermal bits 7:5 hold the thermistor beta code, reset 001.
// - thermal bits 2:0 set die limit 80 C plus 5 C per step, reset 100.
`default_nettype none
`include "charger_cfg_regs.vh"

module charger_config_registers (
    // clock and reset
    input  wire        ref_clk,
    input  wire        rst_b,
    // register port from the serial bus target
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    output reg         reg_rvalid,
    output reg         reg_hit,
    // lock from the device
    input  wire        charger_write_lock,
    // raw fields
    output reg  [5:0]  vreg_code,
    output reg         recharge_sel,
    output reg         thermistor_bias_sel,
    output reg         safety_timer_double,
    output reg  [1:0]  fast_charge_timeout,
    output reg  [1:0]  precharge_timeout,
    output reg  [1:0]  topoff_duration,
    output reg  [2:0]  thermistor_beta_code,
    output reg  [2:0]  die_temp_limit_code,
    // decoded settings
    output reg  [12:0] vreg_target_mv,
    output reg  [12:0] recharge_mv,
    output reg  [10:0] fast_limit_min,
    output reg  [7:0]  precharge_limit_min,
    output reg  [7:0]  topoff_limit_dmin,
    output reg  [6:0]  die_temp_limit_c
);

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    // used only by the hit flag; write gating compares each offset itself
    function addr_known;
        input [7:0] a;
        begin
            addr_known = (a == `OFS_CHARGE_VOLTAGE_CONFIG) ||
                         (a == `OFS_CHARGE_TIMER_CONFIG) ||
                         (a == `OFS_THERMAL_CONFIG);
        end
    endfunction

    // reset images of the registers, sliced so the field copies reset in step
    localparam [7:0] VOLT_RST  = `RST_CHARGE_VOLTAGE_CONFIG;
    localparam [7:0] TIMER_RST = `RST_CHARGE_TIMER_CONFIG;
    localparam [7:0] THERM_RST = `RST_THERMAL_CONFIG;

    wire [7:0] volt_q;
    wire [7:0] timer_q;
    wire [7:0] therm_q;
    wire       wr_volt;
    wire       wr_timer;
    wire       wr_therm;

    // lock gates only the two protected registers
    assign wr_volt  = reg_wr && !charger_write_lock &&
                      (reg_addr == `OFS_CHARGE_VOLTAGE_CONFIG);
    assign wr_timer = reg_wr && !charger_write_lock &&
                      (reg_addr == `OFS_CHARGE_TIMER_CONFIG);
    assign wr_therm = reg_wr && (reg_addr == `OFS_THERMAL_CONFIG);

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    // reset values carry the documented field defaults
    charger_cfg_store #(
        .RESET_VALUE (`RST_CHARGE_VOLTAGE_CONFIG)
    ) u_volt (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .wr_en   (wr_volt),
        .wr_data (reg_wdata),
        .value   (volt_q)
    );

    charger_cfg_store #(
        .RESET_VALUE (`RST_CHARGE_TIMER_CONFIG)
    ) u_timer (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .wr_en   (wr_timer),
        .wr_data (reg_wdata),
        .value   (timer_q)
    );

    charger_cfg_store #(
        .RESET_VALUE (`RST_THERMAL_CONFIG)
    ) u_therm (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .wr_en   (wr_therm),
        .wr_data (reg_wdata),
        .value   (therm_q)
    );

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    reg [7:0] next_rdata;

    // reads ignore the lock; unmapped addresses read zero
    always @* begin
        case (reg_addr)
            `OFS_CHARGE_VOLTAGE_CONFIG: next_rdata = volt_q;
            `OFS_CHARGE_TIMER_CONFIG:   next_rdata = timer_q;
            `OFS_THERMAL_CONFIG:        next_rdata = therm_q;
            default:                    next_rdata = 8'h00;
        endcase
    end

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
            reg_hit    <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            reg_hit    <= (reg_rd || reg_wr) && addr_known(reg_addr);
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // decoded settings
    // ------------------------------------------------------------------
    reg [5:0]  sat_code;
    reg [12:0] next_vreg_mv;
    reg [10:0] fast_base;
    reg [7:0]  pre_base;

    // saturate above the top code so the analog loop never sees > 4.60 V
    always @* begin
        if (volt_q[`VREG_CODE_MSB:`VREG_CODE_LSB] >= `VREG_MAX_CODE) begin
            sat_code = `VREG_MAX_CODE;
        end else begin
            sat_code = volt_q[`VREG_CODE_MSB:`VREG_CODE_LSB];
        end
        next_vreg_mv = `VREG_BASE_MV + `VREG_STEP_MV * {7'h00, sat_code};
        fast_base = `FAST_BASE_MIN +
                    `FAST_STEP_MIN * {9'h000, timer_q[`FAST_TIMER_MSB:`FAST_TIMER_LSB]};
        pre_base  = `PRECHARGE_STEP_MIN +
                    `PRECHARGE_STEP_MIN *
                    {6'h00, timer_q[`PRECHARGE_TIMER_MSB:`PRECHARGE_TIMER_LSB]};
    end

    // ------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------
    // every output is registered; settings trail the register by one cycle
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            vreg_code            <= VOLT_RST[`VREG_CODE_MSB:`VREG_CODE_LSB];
            recharge_sel         <= VOLT_RST[`RECHARGE_SEL_BIT];
            thermistor_bias_sel  <= TIMER_RST[`BIAS_SEL_BIT];
            safety_timer_double  <= TIMER_RST[`TIMER_DOUBLE_BIT];
            fast_charge_timeout  <= TIMER_RST[`FAST_TIMER_MSB:`FAST_TIMER_LSB];
            precharge_timeout    <= TIMER_RST[`PRECHARGE_TIMER_MSB:`PRECHARGE_TIMER_LSB];
            topoff_duration      <= TIMER_RST[`TOPOFF_MSB:`TOPOFF_LSB];
            thermistor_beta_code <= THERM_RST[`BETA_CODE_MSB:`BETA_CODE_LSB];
            die_temp_limit_code  <= THERM_RST[`TEMP_LIMIT_MSB:`TEMP_LIMIT_LSB];
            vreg_target_mv       <= `RST_VREG_TARGET_MV;
            recharge_mv          <= `RST_RECHARGE_MV;
            fast_limit_min       <= `RST_FAST_LIMIT_MIN;
            precharge_limit_min  <= `RST_PRECHARGE_LIMIT_MIN;
            topoff_limit_dmin    <= `RST_TOPOFF_LIMIT_DMIN;
            die_temp_limit_c     <= `RST_DIE_TEMP_LIMIT_C;
        end else begin
            vreg_code            <= volt_q[`VREG_CODE_MSB:`VREG_CODE_LSB];
            recharge_sel         <= volt_q[`RECHARGE_SEL_BIT];
            thermistor_bias_sel  <= timer_q[`BIAS_SEL_BIT];
            safety_timer_double  <= timer_q[`TIMER_DOUBLE_BIT];
            fast_charge_timeout  <= timer_q[`FAST_TIMER_MSB:`FAST_TIMER_LSB];
            precharge_timeout    <= timer_q[`PRECHARGE_TIMER_MSB:`PRECHARGE_TIMER_LSB];
            topoff_duration      <= timer_q[`TOPOFF_MSB:`TOPOFF_LSB];
            thermistor_beta_code <= therm_q[`BETA_CODE_MSB:`BETA_CODE_LSB];
            die_temp_limit_code  <= therm_q[`TEMP_LIMIT_MSB:`TEMP_LIMIT_LSB];
            vreg_target_mv       <= next_vreg_mv;
            recharge_mv          <= next_vreg_mv - {4'h0, (volt_q[`RECHARGE_SEL_BIT] ?
                                    `RECHARGE_HIGH_MV : `RECHARGE_LOW_MV)};
            // doubling is a left shift of the base duration
            fast_limit_min       <= timer_q[`TIMER_DOUBLE_BIT] ?
                                    {fast_base[9:0], 1'b0} : fast_base;
            precharge_limit_min  <= timer_q[`TIMER_DOUBLE_BIT] ?
                                    {pre_base[6:0], 1'b0} : pre_base;
            topoff_limit_dmin    <= `TOPOFF_STEP_DMIN *
                                    {6'h00, timer_q[`TOPOFF_MSB:`TOPOFF_LSB]};
            die_temp_limit_c     <= `TEMP_BASE_C + `TEMP_STEP_C *
                                    {4'h0, therm_q[`TEMP_LIMIT_MSB:`TEMP_LIMIT_LSB]};
        end
    end

endmodule

`default_nettype wire

/* tb/charger_config_registers_asserts.sv */
/*
 * concurrent checks on the charger configuration register bank ports.
 * assumes: bound to charger_config_registers; single clock ref_clk.
 */
`default_nettype none

module charger_config_registers_asserts (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_b,
    // register port
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic        reg_rvalid,
    input wire logic        reg_hit,
    input wire logic        charger_write_lock,
    // fields and decoded settings
    input wire logic [5:0]  vreg_code,
    input wire logic        recharge_sel,
    input wire logic        safety_timer_double,
    input wire logic [1:0]  fast_charge_timeout,
    input wire logic [1:0]  precharge_timeout,
    input wire logic [1:0]  topoff_duration,
    input wire logic [2:0]  die_temp_limit_code,
    input wire logic [12:0] vreg_target_mv,
    input wire logic [12:0] recharge_mv,
    input wire logic [10:0] fast_limit_min,
    input wire logic [7:0]  precharge_limit_min,
    input wire logic [7:0]  topoff_limit_dmin,
    input wire logic [6:0]  die_temp_limit_c
);
    timeunit 1ns;
    timeprecision 100ps;

    // -----------------------------------------------------------------
    // properties
    // -----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // decodes are only compared once their source field has settled
    a_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read got no valid");
    a_no_stray_valid: assert property (!reg_rd |=> !reg_rvalid)
        else $error("valid without read");
    a_hit_mapped: assert property ((reg_wr || reg_rd) && reg_addr >= 8'h15
        && reg_addr <= 8'h17 |=> reg_hit) else $error("mapped access missed");
    a_hit_unmapped: assert property (!((reg_wr || reg_rd) && reg_addr >= 8'h15
        && reg_addr <= 8'h17) |=> !reg_hit) else $error("hit without mapped access");
    a_locked_hold: assert property (reg_wr && charger_write_lock && reg_addr == 8'h15
        |=> ##1 $stable(vreg_code) && $stable(recharge_sel)) else $error("locked write landed");
    a_locked_timer: assert property (reg_wr && charger_write_lock
        && reg_addr == 8'h16 |=> ##1 $stable({safety_timer_double, fast_charge_timeout,
        precharge_timeout, topoff_duration})) else $error("locked timer write landed");
    a_vreg_map: assert property ($stable(vreg_code) |-> vreg_target_mv ==
        ((vreg_code >= 6'h32) ? 13'h11F8 : 13'h0E10 + 13'h0014 * vreg_code))
        else $error("bad target");
    a_recharge_gap: assert property ($stable(vreg_target_mv)
        && $stable(recharge_sel)
        |-> recharge_mv == vreg_target_mv - (recharge_sel ? 13'h00F0 : 13'h008C))
        else $error("bad gap");
    a_fast_timer: assert property ($stable({safety_timer_double, fast_charge_timeout})
        |-> fast_limit_min == (11'h0B4 + 11'h078 * fast_charge_timeout) << safety_timer_double)
        else $error("bad fast limit");
    a_pre_timer: assert property ($stable({safety_timer_double, precharge_timeout})
        |-> precharge_limit_min == (8'h0F + 8'h0F * precharge_timeout) << safety_timer_double)
        else $error("bad precharge limit");
    a_topoff_step: assert property ($stable(topoff_duration)
        |-> topoff_limit_dmin == 8'h40 * topoff_duration) else $error("bad topoff");
    a_temp_limit: assert property ($stable(die_temp_limit_code)
        |-> die_temp_limit_c == 7'h50 + 7'h05 * die_temp_limit_code)
        else $error("bad temp limit");
endmodule

bind charger_config_registers charger_config_registers_asserts chk_u (
    .ref_clk, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_rvalid, .reg_hit,
    .charger_write_lock, .vreg_code, .recharge_sel, .safety_timer_double,
    .fast_charge_timeout, .precharge_timeout, .topoff_duration, .die_temp_limit_code,
    .vreg_target_mv, .recharge_mv, .fast_limit_min, .precharge_limit_min,
    .topoff_limit_dmin, .die_temp_limit_c
);

`default_nettype wire

/* tb/charger_host_model.sv */
/*
 * host side of the register port: single-byte reads and writes.
 * assumes: the bank samples the strobes on the rising edge of ref_clk.
 */
`default_nettype none

module charger_host_model (
    // clock
    input  wire logic       ref_clk,
    // register port toward the bank
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    output var  logic       reg_wr,
    output var  logic       reg_rd
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // one-edge strobe; idle lines are scrambled so nothing leans on stale values
    task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
endmodule

`default_nettype wire

/* tb/test_charger_config_registers.sv */
/*
 * self-checking bench for the charger configuration register bank.
 * assumes: host model drives the register port; lock driven here.
 */
`default_nettype none

module test_charger_config_registers;
    timeunit 1ns;
    timeprecision 100ps;

    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        lock = 1'b0;
    wire  [7:0]  reg_addr, reg_wdata;
    wire         reg_wr, reg_rd;
    logic [7:0]  reg_rdata, d, precharge_limit_min, topoff_limit_dmin;
    logic        reg_rvalid, reg_hit, recharge_sel, thermistor_bias_sel, safety_timer_double;
    logic [5:0]  vreg_code;
    logic [1:0]  fast_charge_timeout, precharge_timeout, topoff_duration;
    logic [2:0]  thermistor_beta_code, die_temp_limit_code;
    logic [12:0] vreg_target_mv, recharge_mv;
    logic [10:0] fast_limit_min;
    logic [6:0]  die_temp_limit_c;
    logic [15:0] e;
    logic [15:0] exp_q[$];
    logic [7:0]  shadow [3];
    logic [5:0]  codes [5] = '{6'h00, 6'h1E, 6'h31, 6'h32, 6'h3F};
    int          fail_count = 0, compares = 0, cycles = 0, seed = 43390;

    always #4 ref_clk = ~ref_clk;

    charger_host_model host_u (.ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);

    charger_config_registers dut_u (
        .ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
        .reg_hit, .charger_write_lock(lock), .vreg_code, .recharge_sel, .thermistor_bias_sel,
        .safety_timer_double, .fast_charge_timeout, .precharge_timeout, .topoff_duration,
        .thermistor_beta_code, .die_temp_limit_code, .vreg_target_mv, .recharge_mv,
        .fast_limit_min, .precharge_limit_min, .topoff_limit_dmin, .die_temp_limit_c
    );

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // shadow follows only writes the lock lets through
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        host_u.access(a, v, 1'b1);
        if (a >= 8'h15 && a <= 8'h17 && !(lock && a != 8'h17)) shadow[a - 8'h15] = v;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] v);
        exp_q.push_back({8'h00, v});
        host_u.access(a, 8'h00, 1'b0);
    endtask

    // fields move one edge after the write is taken; settle waits two
    task automatic settle();
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    // read results are matched oldest-first against the noted values
    always @(posedge ref_clk) begin
        if (reg_rvalid === 1'b1) begin
            check(reg_rdata, exp_q.size() ? exp_q.pop_front() : 16'hFFFF);
        end
    end

    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            end_of_test();
        end
    end

    initial begin
        shadow = '{8'h1E, 8'h95, 8'h24};
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        #1;
        check(vreg_code, 16'h001E);
        check(recharge_sel, 16'h0000);
        check(thermistor_bias_sel, 16'h0001);
        check(safety_timer_double, 16'h0000);
        check(thermistor_beta_code, 16'h0001);
        check(die_temp_limit_code, 16'h0004);
        check(vreg_target_mv, 16'h1068);
        check(recharge_mv, 16'h0FDC);
        check(fast_limit_min, 16'h012C);
        check(precharge_limit_min, 16'h001E);
        check(topoff_limit_dmin, 16'h0040);
        check(die_temp_limit_c, 16'h0064);
        rd(8'h15, 8'h1E);
        rd(8'h16, 8'h95);
        rd(8'h17, 8'h24);
        rd(8'h18, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            d[6:0] = {i[2], i[1:0], i[1:0], i[1:0]};
            wr(8'h16, d);
            wr(8'h17, {i[2:0], d[4:3], i[2:0]});
            settle();
            check(fast_charge_timeout, i[1:0]);
            check(precharge_timeout, i[1:0]);
            check(topoff_duration, i[1:0]);
            check(fast_limit_min, (16'h00B4 + 16'h0078 * i[1:0]) << i[2]);
            check(precharge_limit_min, (16'h000F * (i[1:0] + 16'h0001)) << i[2]);
            check(topoff_limit_dmin, 16'h0040 * i[1:0]);
            check(safety_timer_double, i[2]);
            check(thermistor_bias_sel, d[7]);
            check(die_temp_limit_code, i[2:0]);
            check(die_temp_limit_c, 16'h0050 + 16'h0005 * i[2:0]);
            check(thermistor_beta_code, i[2:0]);
            rd(8'h16, shadow[1]);
        end
        $display("test timer and thermal done");
        foreach (codes[k]) begin
            wr(8'h15, {d[k], k[0], codes[k]});
            settle();
            e = (codes[k] >= 6'h32) ? 16'h11F8 : 16'h0E10 + 16'h0014 * codes[k];
            check(vreg_code, codes[k]);
            check(recharge_sel, k[0]);
            check(vreg_target_mv, e);
            check(recharge_mv, e - (k[0] ? 16'h00F0 : 16'h008C));
            rd(8'h15, shadow[0]);
        end
        $display("test voltage done");
        @(posedge ref_clk);
        lock <= 1'b1;
        for (int a = 8'h15; a <= 8'h17; a++) wr(a[7:0], $random(seed));
        settle();
        check(vreg_code, shadow[0][5:0]);
        check(fast_charge_timeout, shadow[1][5:4]);
        check(die_temp_limit_code, shadow[2][2:0]);
        for (int a = 8'h15; a <= 8'h17; a++) rd(a[7:0], shadow[a - 8'h15]);
        lock <= 1'b0;
        wr(8'h15, 8'h4A);
        rd(8'h15, 8'h4A);
        repeat (4) @(posedge ref_clk);
        check(exp_q.size(), 16'h0000);
        $display("test lock done");
        end_of_test();
    end
endmodule

`default_nettype wire
